// file: common/pllr_pkg.sv
`default_nettype none
package pllr_pkg;
	// serial port framing
	localparam logic [7:0] CHIP_ADDR = 8'h9E;
	localparam logic [7:0] REG_RESET = 8'h00;
	// register addresses on the port
	localparam logic [6:0] ADR_DEV_CTRL = 7'h02;
	localparam logic [6:0] ADR_DEV_CFG1 = 7'h03;
	localparam logic [6:0] ADR_GLOB_CFG = 7'h05;
	localparam logic [6:0] ADR_RATIO_B3 = 7'h06;
	localparam logic [6:0] ADR_RATIO_B2 = 7'h07;
	localparam logic [6:0] ADR_RATIO_B1 = 7'h08;
	localparam logic [6:0] ADR_RATIO_B0 = 7'h09;
	localparam logic [6:0] ADR_FUNC_CFG1 = 7'h16;
	localparam logic [6:0] ADR_FUNC_CFG2 = 7'h17;
	// storage slots
	localparam int NSLOTS = 9;
	localparam logic [3:0] SLOT_CTRL = 4'h0;
	localparam logic [3:0] SLOT_CFG1 = 4'h1;
	localparam logic [3:0] SLOT_GLOB = 4'h2;
	localparam logic [3:0] SLOT_R3 = 4'h3;
	localparam logic [3:0] SLOT_R2 = 4'h4;
	localparam logic [3:0] SLOT_R1 = 4'h5;
	localparam logic [3:0] SLOT_R0 = 4'h6;
	localparam logic [3:0] SLOT_F1 = 4'h7;
	localparam logic [3:0] SLOT_F2 = 4'h8;
	localparam logic [3:0] SLOT_NONE = 4'hF;
	// field positions
	localparam int CTRL_MAIN_DIS = 0;
	localparam int CTRL_AUX_DIS = 1;
	localparam int CFG1_EN = 0;
	localparam int CFG1_SRC_LO = 1;
	localparam int CFG1_RMOD_LO = 5;
	localparam int GLOB_EN = 0;
	localparam int GLOB_FREEZE = 3;
	localparam int F1_EN = 4;
	localparam int F1_LOCK_CFG = 6;
	localparam int F1_SKIP = 7;
	localparam int F2_LF = 3;
	localparam int F2_UNL = 4;
	// aux source codes
	localparam logic [1:0] AUX_SYNTH_A = 2'b00;
	localparam logic [1:0] AUX_CLKIN = 2'b01;
	localparam logic [1:0] AUX_SYNTH_B = 2'b10;
	localparam logic [1:0] AUX_LOCK = 2'b11;
	// effective ratio: unsigned 24.24
	localparam int EFF_W = 48;
	// timing
	localparam int REF_PERIOD_PS = 5000;
	localparam int LOCK_HOLD_NS = 100;
	localparam logic [7:0] LOCK_HOLD_CYCLES =
		8'((LOCK_HOLD_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS);
	localparam logic [3:0] STRAP_CYCLES = 4'h8;
	localparam int unsigned GAP_CYCLES_DEFAULT = 8388608;
	localparam logic UNLOCK_RESET = 1'b1;
	typedef enum logic [4:0] {
		PS_IDLE = 5'b00001,
		PS_ADDR = 5'b00010,
		PS_PTR = 5'b00100,
		PS_DATA = 5'b01000,
		PS_SKIP = 5'b10000
	} pllr_port_state_t;
endpackage
`default_nettype wire

// file: hw/pllr_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module pllr_ctrl #(
	parameter int unsigned GAP_CYCLES = pllr_pkg::GAP_CYCLES_DEFAULT
) (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic SYNTH_CLK,
	input wire logic CLK_IN,
	input wire logic LOOP_LOCKED,
	input wire logic REF_DISCONT,
	input wire logic PORT_BIT_CLOCK,
	input wire logic PORT_SERIAL_INPUT,
	input wire logic ADDRESS_OR_SELECT_PIN,
	output logic CLK_OUT_O,
	output logic CLK_OUT_OE,
	output logic AUX_OUT_O,
	output logic AUX_OUT_OE,
	output logic UNLOCKED,
	output logic SPI_MODE,
	output logic TWO_WIRE_ADDR,
	output logic [pllr_pkg::EFF_W-1:0] EFFECTIVE_RATIO
);
	import pllr_pkg::*;

	if (GAP_CYCLES < 16 || GAP_CYCLES > 16777215) begin : g_bad_gap
		$error("GAP_CYCLES out of range");
	end

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RESET);

	function automatic logic [3:0] slot_of(input logic [6:0] a);
		unique case (a)
			ADR_DEV_CTRL: slot_of = SLOT_CTRL;
			ADR_DEV_CFG1: slot_of = SLOT_CFG1;
			ADR_GLOB_CFG: slot_of = SLOT_GLOB;
			ADR_RATIO_B3: slot_of = SLOT_R3;
			ADR_RATIO_B2: slot_of = SLOT_R2;
			ADR_RATIO_B1: slot_of = SLOT_R1;
			ADR_RATIO_B0: slot_of = SLOT_R0;
			ADR_FUNC_CFG1: slot_of = SLOT_F1;
			ADR_FUNC_CFG2: slot_of = SLOT_F2;
			default: slot_of = SLOT_NONE;
		endcase
	endfunction

	// two-flop synchronisers for every outside input except RESET
	logic [6:0] raw, s1_q, s2_q;
	assign raw = {REF_DISCONT, LOOP_LOCKED, ADDRESS_OR_SELECT_PIN, PORT_SERIAL_INPUT,
		PORT_BIT_CLOCK, CLK_IN, SYNTH_CLK};
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
		end
	end
	wire synth_s = s2_q[0];
	wire clkin_s = s2_q[1];
	wire bclk_s = s2_q[2];
	wire sdi_s = s2_q[3];
	wire sel_s = s2_q[4];
	wire locked_s = s2_q[5];
	wire ref_disc_s = s2_q[6];

	// mode strap and serial mode detection
	logic [3:0] strap_cnt_q;
	logic sel_prev_q, spi_q, addr_bit_q, bclk_prev_q;
	wire strap_done = (strap_cnt_q == STRAP_CYCLES);
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			strap_cnt_q <= 4'h0;
			sel_prev_q <= 1'b0;
			spi_q <= 1'b0;
			addr_bit_q <= 1'b0;
			bclk_prev_q <= 1'b0;
		end else begin
			sel_prev_q <= sel_s;
			bclk_prev_q <= bclk_s;
			if (!strap_done) begin
				strap_cnt_q <= strap_cnt_q + 4'h1;
				addr_bit_q <= sel_s;
			end
			if (strap_done && sel_prev_q && !sel_s) begin
				spi_q <= 1'b1;
			end
		end
	end

	// serial byte receiver, write only
	pllr_port_state_t st_q, st_d;
	logic [7:0] sh_q;
	logic [2:0] bit_cnt_q;
	logic [6:0] ptr_q;
	logic step_q;
	wire frame = spi_q & ~sel_s;
	wire bit_rise = frame & bclk_s & ~bclk_prev_q;
	wire [7:0] sh_next = {sh_q[6:0], sdi_s};
	wire byte_done = bit_rise & (bit_cnt_q == 3'd7);
	wire wr_pulse = byte_done & (st_q == PS_DATA);
	wire [3:0] wr_slot = slot_of(ptr_q);

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			PS_IDLE: if (frame) st_d = PS_ADDR;
			PS_ADDR: if (byte_done) st_d = (sh_next == CHIP_ADDR) ? PS_PTR : PS_SKIP;
			PS_PTR: if (byte_done) st_d = PS_DATA;
			PS_DATA: st_d = PS_DATA;
			PS_SKIP: st_d = PS_SKIP;
			default: st_d = PS_IDLE;
		endcase
		if (!frame) st_d = PS_IDLE;
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			st_q <= PS_IDLE;
			sh_q <= 8'h00;
			bit_cnt_q <= 3'd0;
			ptr_q <= 7'h00;
			step_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (!frame) begin
				bit_cnt_q <= 3'd0;
			end else if (bit_rise) begin
				sh_q <= sh_next;
				bit_cnt_q <= bit_cnt_q + 3'd1;
			end
			if (byte_done && st_q == PS_PTR) begin
				ptr_q <= sh_next[6:0];
				step_q <= sh_next[7];
			end else if (wr_pulse) begin
				ptr_q <= ptr_q + {6'h00, step_q};
			end
		end
	end

	// shadow registers and applied copies; freeze holds the applied set
	logic [7:0] sh_reg_q [NSLOTS];
	logic [7:0] ap_q [NSLOTS];
	wire freeze = sh_reg_q[SLOT_GLOB][GLOB_FREEZE];
	for (genvar i = 0; i < NSLOTS; i++) begin : g_reg
		always_ff @(posedge REF_CLK) begin
			if (RESET) begin
				sh_reg_q[i] <= REG_RESET;
				ap_q[i] <= REG_RESET;
			end else begin
				if (wr_pulse && wr_slot == 4'(i)) sh_reg_q[i] <= sh_next;
				if (!freeze) ap_q[i] <= sh_reg_q[i];
			end
		end
	end

	wire main_dis = ap_q[SLOT_CTRL][CTRL_MAIN_DIS];
	wire aux_dis = ap_q[SLOT_CTRL][CTRL_AUX_DIS];
	wire [1:0] aux_src = ap_q[SLOT_CFG1][CFG1_SRC_LO +: 2];
	wire [2:0] rmod = ap_q[SLOT_CFG1][CFG1_RMOD_LO +: 3];
	wire lock_cfg = ap_q[SLOT_F1][F1_LOCK_CFG];
	wire skip_en = ap_q[SLOT_F1][F1_SKIP];
	wire lf_fmt = ap_q[SLOT_F2][F2_LF];
	wire unl_en = ap_q[SLOT_F2][F2_UNL];
	wire cfg_en_all = ap_q[SLOT_CFG1][CFG1_EN] & ap_q[SLOT_GLOB][GLOB_EN]
		& ap_q[SLOT_F1][F1_EN];
	wire [31:0] rud = {ap_q[SLOT_R3], ap_q[SLOT_R2], ap_q[SLOT_R1], ap_q[SLOT_R0]};
	wire [35:0] key_ap = {lf_fmt, rmod, rud};

	// effective ratio as unsigned 24.24
	wire [EFF_W-1:0] eff_base = lf_fmt ? {12'h000, rud, 4'h0} : {4'h0, rud, 12'h000};
	wire [EFF_W-1:0] eff_d = rmod[2] ? (eff_base >> ({1'b0, rmod[1:0]} + 3'd1))
		: (eff_base << rmod[1:0]);

	logic [35:0] key_prev_q;
	logic live_q;
	logic [EFF_W-1:0] eff_q;
	wire ratio_chg = (key_ap != key_prev_q);
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			key_prev_q <= '0;
			live_q <= 1'b0;
			eff_q <= '0;
		end else begin
			key_prev_q <= key_ap;
			live_q <= cfg_en_all & (rud != 32'h0000_0000);
			eff_q <= eff_d;
		end
	end

	// reference input clock monitor
	localparam logic [23:0] LIM = 24'(GAP_CYCLES - 1);
	localparam logic [23:0] LIM_M1 = 24'(GAP_CYCLES - 2);
	logic clkin_prev_q, per_ok_q, base_ok_q, unlocked_q;
	logic [23:0] per_q, last_q, base_q;
	wire clkin_rise = clkin_s & ~clkin_prev_q;
	wire per_valid = per_ok_q & (per_q != LIM);
	wire gap_hit = ~clkin_rise & (per_q == LIM_M1);
	wire [27:0] per28 = {4'h0, per_q};
	wire [27:0] base28 = {4'h0, base_q};
	wire [27:0] base10 = base28 * 28'd10;
	wire drift = (per28 * 28'd13 < base10) | (per28 * 28'd7 > base10);
	wire [23:0] diff = (per_q > last_q) ? per_q - last_q : last_q - per_q;
	wire stepped = diff > {3'b000, last_q[23:3]};
	wire clkin_fault = (gap_hit & ~skip_en)
		| (clkin_rise & per_valid & base_ok_q & (drift | stepped));
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			clkin_prev_q <= 1'b0;
			per_ok_q <= 1'b0;
			base_ok_q <= 1'b0;
			per_q <= 24'h00_0000;
			last_q <= 24'h00_0000;
			base_q <= 24'h00_0000;
		end else begin
			clkin_prev_q <= clkin_s;
			if (clkin_rise) begin
				per_q <= 24'h00_0000;
				per_ok_q <= 1'b1;
				if (per_valid) last_q <= per_q;
				if (per_valid && !unlocked_q && !base_ok_q) begin
					base_q <= per_q;
					base_ok_q <= 1'b1;
				end
			end else if (per_q != LIM) begin
				per_q <= per_q + 24'h00_0001;
			end
			if (unlocked_q) base_ok_q <= 1'b0;
		end
	end

	// lock state: any cause sets, a held lock report clears, set wins
	logic [7:0] hold_q;
	wire unl_set = ratio_chg | ref_disc_s | clkin_fault;
	wire unl_clear = unlocked_q & locked_s & (hold_q == LOCK_HOLD_CYCLES);
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			unlocked_q <= UNLOCK_RESET;
			hold_q <= 8'h00;
		end else begin
			if (unl_set || !locked_s || !unlocked_q) hold_q <= 8'h00;
			else if (hold_q != LOCK_HOLD_CYCLES) hold_q <= hold_q + 8'h01;
			if (unl_set) unlocked_q <= 1'b1;
			else if (unl_clear) unlocked_q <= 1'b0;
		end
	end

	// output gating, enables move only while the synthesized clock is low, except aux_oe_q when the aux source is not a synthesized clock
	logic main_run_q, main_oe_q, aux_run_q, aux_oe_q, clk_out_q, aux_out_q;
	wire boundary = ~synth_s;
	wire run_want = live_q & (~unlocked_q | unl_en);
	wire aux_is_clk = ~aux_src[0];
	wire lock_od = (aux_src == AUX_LOCK) & lock_cfg;
	wire aux_oe_d = ~live_q | (lock_od ? (~aux_dis & unlocked_q) : ~aux_dis);
	logic aux_out_d;
	always_comb begin
		unique case (aux_src)
			AUX_SYNTH_A, AUX_SYNTH_B: aux_out_d = synth_s & aux_run_q;
			AUX_CLKIN: aux_out_d = clkin_s;
			default: aux_out_d = ~lock_cfg & ~unlocked_q;
		endcase
		if (!live_q) aux_out_d = 1'b0;
	end
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			main_run_q <= 1'b0;
			main_oe_q <= 1'b1;
			aux_run_q <= 1'b0;
			aux_oe_q <= 1'b1;
			clk_out_q <= 1'b0;
			aux_out_q <= 1'b0;
		end else begin
			if (boundary) begin
				main_run_q <= ~main_dis & run_want;
				main_oe_q <= ~main_dis | ~live_q;
				aux_run_q <= ~aux_dis & run_want;
			end
			if (boundary || !aux_is_clk) aux_oe_q <= aux_oe_d;
			clk_out_q <= synth_s & main_run_q & live_q;
			aux_out_q <= aux_out_d;
		end
	end

	assign CLK_OUT_O = clk_out_q;
	assign CLK_OUT_OE = main_oe_q;
	assign AUX_OUT_O = aux_out_q;
	assign AUX_OUT_OE = aux_oe_q;
	assign UNLOCKED = unlocked_q;
	assign SPI_MODE = spi_q;
	assign TWO_WIRE_ADDR = addr_bit_q;
	assign EFFECTIVE_RATIO = eff_q;

	main_hiz_a: assert property (
		(boundary && main_dis && live_q) |=> !main_oe_q)
		else $error("main driver not released when disabled");
	unlock_low_a: assert property (
		(boundary && unlocked_q && !unl_en) |=> ##1 !clk_out_q)
		else $error("main clock driven while unlocked");
	aux_lock_a: assert property (
		(aux_src == AUX_LOCK && !lock_cfg && live_q) |=> (aux_out_q == !$past(unlocked_q)))
		else $error("lock indicator wrong on aux");
	aux_copy_a: assert property (
		($rose(aux_out_q) && $past(aux_is_clk)) |-> $past(aux_run_q, 1))
		else $error("aux clock copy without run enable");
	no_runt_a: assert property (
		($fell(main_run_q) || $rose(main_run_q)) |-> $past(!synth_s))
		else $error("main gate moved while clock high");
	ratio_unlock_a: assert property (
		ratio_chg |=> unlocked_q [*2])
		else $error("ratio change did not force unlock");
	pre_cfg_low_a: assert property (
		!live_q |=> (!clk_out_q && !aux_out_q))
		else $error("output toggled before valid ratio");
	freeze_hold_a: assert property (
		freeze |=> $stable(key_ap))
		else $error("applied ratio changed under freeze");
	ptr_hold_a: assert property (
		(wr_pulse && !step_q) |=> (ptr_q == $past(ptr_q)))
		else $error("pointer moved without auto step");
endmodule
`default_nettype wire

// file: bench/pllr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pllr_host_model (
	input wire logic REF_CLK,
	output logic PORT_BIT_CLOCK,
	output logic PORT_SERIAL_INPUT,
	output logic ADDRESS_OR_SELECT_PIN
);
	// bit clock rests low, select rests high between frames
	initial begin
		PORT_BIT_CLOCK = 1'b0;
		PORT_SERIAL_INPUT = 1'b0;
		ADDRESS_OR_SELECT_PIN = 1'b1;
	end
	task automatic sel_set(input logic v);
		repeat (13) @(posedge REF_CLK);
		ADDRESS_OR_SELECT_PIN <= v;
		// stale data bit shown inverted once the frame is over
		if (v)
			PORT_SERIAL_INPUT <= ~PORT_SERIAL_INPUT;
		repeat (12) @(posedge REF_CLK);
	endtask
	// msb first, data set while clock low, stable around the rise
	task automatic byte_out(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			PORT_SERIAL_INPUT <= b[i];
			repeat (12) @(posedge REF_CLK);
			PORT_BIT_CLOCK <= 1'b1;
			repeat (13) @(posedge REF_CLK);
			PORT_BIT_CLOCK <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// file: bench/pllr_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pllr_ctrl_tb_top;
	import pllr_pkg::*;
	logic clk = 1'b0, rst = 1'b1, synth = 1'b0, clk_in = 1'b0, locked = 1'b1, discont = 1'b0;
	logic in_run = 1'b1, unl_seen = 1'b0;
	logic bclk, sdi, sel, o_main, oe_main, o_aux, oe_aux, unl, spi, twa;
	logic [EFF_W-1:0] ratio;
	logic [4:0] div = 5'h00;
	logic [5:0] m, a;
	int error_cnt = 0, checks_done = 0, cyc = 0;
	// modifier code, aux source, expected ratio shift, expected aux high count
	logic [7:0] rows [8][4] = '{'{8'h1, 8'h0, 8'h19, 8'h10}, '{8'h2, 8'h1, 8'h1A, 8'h08},
		'{8'h3, 8'h2, 8'h1B, 8'h10}, '{8'h4, 8'h3, 8'h17, 8'h20}, '{8'h5, 8'h0, 8'h16, 8'h10},
		'{8'h6, 8'h1, 8'h15, 8'h08}, '{8'h7, 8'h2, 8'h14, 8'h10}, '{8'h0, 8'h3, 8'h18, 8'h20}};
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		div <= div + 5'h01;
		synth <= div[2];
		if (in_run)
			clk_in <= (div[4:3] == 2'h0);
		if (unl === 1'b1)
			unl_seen <= 1'b1;
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	pllr_ctrl #(.GAP_CYCLES(200)) pllr_ctrl_inst (.REF_CLK(clk), .RESET(rst), .SYNTH_CLK(synth),
		.CLK_IN(clk_in), .LOOP_LOCKED(locked), .REF_DISCONT(discont), .PORT_BIT_CLOCK(bclk),
		.PORT_SERIAL_INPUT(sdi), .ADDRESS_OR_SELECT_PIN(sel), .CLK_OUT_O(o_main),
		.CLK_OUT_OE(oe_main), .AUX_OUT_O(o_aux), .AUX_OUT_OE(oe_aux), .UNLOCKED(unl),
		.SPI_MODE(spi), .TWO_WIRE_ADDR(twa), .EFFECTIVE_RATIO(ratio));
	pllr_host_model pllr_host_model_inst (.REF_CLK(clk), .PORT_BIT_CLOCK(bclk),
		.PORT_SERIAL_INPUT(sdi), .ADDRESS_OR_SELECT_PIN(sel));
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic frame(input logic [7:0] ptr, input logic [31:0] d, input int n,
		input logic [7:0] ca = CHIP_ADDR);
		pllr_host_model_inst.sel_set(1'b0);
		pllr_host_model_inst.byte_out(ca);
		pllr_host_model_inst.byte_out(ptr);
		for (int i = n - 1; i >= 0; i--)
			pllr_host_model_inst.byte_out(d[8*i+:8]);
		pllr_host_model_inst.sel_set(1'b1);
		repeat (8) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [6:0] adr, input logic [7:0] d);
		frame({1'b0, adr}, {24'h00_0000, d}, 1);
	endtask
	task automatic cnt();
		m = 6'h00;
		a = 6'h00;
		repeat (32) begin
			@(posedge clk);
			#1;
			m += 6'(o_main);
			a += 6'(o_aux);
		end
	endtask
	task automatic note(input string s);
		$display("test %s done", s);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (12) @(posedge clk);
		pllr_host_model_inst.sel_set(1'b0);
		pllr_host_model_inst.sel_set(1'b1);
		chk(48'(spi), 48'h1);
		wr(ADR_GLOB_CFG, 8'h01);
		wr(ADR_FUNC_CFG1, 8'h10);
		frame({1'b1, ADR_RATIO_B3}, 32'h0000_1000, 4);
		repeat (40) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			unl_seen <= 1'b0;
			wr(ADR_DEV_CFG1, {rows[i][0][2:0], 2'h0, rows[i][1][1:0], 1'b1});
			chk(48'(unl_seen), 48'h1);
			repeat (40) @(posedge clk);
			chk(48'(unl), 48'h0);
			chk(ratio, 48'h1 << rows[i][2]);
			cnt();
			chk(48'(m), 48'h10);
			chk(48'(a), 48'(rows[i][3]));
			chk(48'(oe_aux), 48'h1);
			note("row");
		end
		wr(ADR_GLOB_CFG, 8'h09);
		frame({1'b0, ADR_RATIO_B2}, 32'h0000_0020, 2);
		chk(ratio, 48'h0000_0100_0000);
		wr(ADR_GLOB_CFG, 8'h01);
		chk(ratio, 48'h0002_0100_0000);
		wr(ADR_FUNC_CFG2, 8'h08);
		chk(ratio, 48'h0000_0201_0000);
		frame({1'b0, ADR_FUNC_CFG2}, 32'h0000_0000, 1, 8'h9C);
		chk(ratio, 48'h0000_0201_0000);
		note("freeze");
		repeat (40) @(posedge clk);
		wr(ADR_DEV_CTRL, 8'h03);
		chk({oe_main, oe_aux}, 2'h0);
		wr(ADR_DEV_CTRL, 8'h00);
		chk({oe_main, oe_aux}, 2'h3);
		@(posedge clk);
		discont <= 1'b1;
		repeat (20) @(posedge clk);
		chk(48'(unl), 48'h1);
		cnt();
		chk({m, a}, 12'h000);
		wr(ADR_FUNC_CFG2, 8'h18);
		cnt();
		chk(48'(m), 48'h10);
		wr(ADR_FUNC_CFG1, 8'h50);
		chk({oe_aux, o_aux}, 2'h2);
		@(posedge clk);
		discont <= 1'b0;
		repeat (40) @(posedge clk);
		chk(48'(oe_aux), 48'h0);
		// lock report stays high, so a gap only pulses the unlock flag
		unl_seen <= 1'b0;
		in_run <= 1'b0;
		repeat (260) @(posedge clk);
		chk(48'(unl_seen), 48'h1);
		note("unlock");
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		#1;
		chk({o_main, oe_main, o_aux, oe_aux, unl, spi, twa}, 7'h2C);
		chk(ratio, 48'h0000_0000_0000);
		@(posedge clk);
		rst <= 1'b0;
		repeat (14) @(posedge clk);
		#1;
		chk(48'(twa), 48'h1);
		cnt();
		chk({m, a}, 12'h000);
		note("reset");
		tally_and_finish();
	end
endmodule
`default_nettype wire
